// ---- src/rcm_defines.vh ----
`ifndef RCM_DEFINES_VH
`define RCM_DEFINES_VH

// ----------------------------------------
// addresses and register numbers
// ----------------------------------------
`define RCM_RESET_VECTOR 20'h0FFFE
`define RCM_REG_PC 4'h0
`define RCM_REG_SP 4'h1
`define RCM_REG_SR 4'h2
`define RCM_REG_CG 4'h3
`define RCM_REG_RESET 16'h0000

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define RCM_SR_C 0
`define RCM_SR_Z 1
`define RCM_SR_N 2
`define RCM_SR_V 8

// ----------------------------------------
// two-operand opcodes
// ----------------------------------------
`define RCM_OP_MOVE 4'h4
`define RCM_OP_ADD 4'h5
`define RCM_OP_ADDC 4'h6
`define RCM_OP_SUBC 4'h7
`define RCM_OP_SUB 4'h8
`define RCM_OP_CMP 4'h9
`define RCM_OP_DECADD 4'hA
`define RCM_OP_BITTEST 4'hB
`define RCM_OP_BITCLR 4'hC
`define RCM_OP_BITSET 4'hD
`define RCM_OP_XOR 4'hE
`define RCM_OP_AND 4'hF

// ----------------------------------------
// single-operand opcodes
// ----------------------------------------
`define RCM_F2_ROTC 3'h0
`define RCM_F2_SWAP 3'h1
`define RCM_F2_ROTA 3'h2
`define RCM_F2_SEXT 3'h3
`define RCM_F2_PUSH 3'h4
`define RCM_F2_CALL 3'h5
`define RCM_F2_RETI 3'h6

`endif

// ---- src/rcm_core.v ----
// Behaviour
// - sixteen 16-bit registers serve as instruction sources and destinations.
// - registers zero to three are program counter, stack pointer, status, constants.
// - registers four to fifteen are freely readable and writable storage.
// - register-to-register operations finish in one clock cycle, except those that write the program counter.
// - seven source and four destination addressing modes, memory-to-memory operations need no general register.
// - 27-instruction base in three formats plus extended-address prefix word.
// - each instruction except the jumps, SWAP, SEXT, CALL and RETI selects word or byte operand size.
// - memory and peripherals share one data, address and control bus.
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.vh"

module rcm_core (
    input wire sys_clk_in,
    input wire rst_in,
    input wire [15:0] mem_rdata_in,
    output reg [19:0] mem_addr_out,
    output reg [15:0] mem_wdata_out,
    output reg mem_rd_out,
    output reg mem_wr_out,
    output reg mem_byte_out
);

// ----------------------------------------
// states
// ----------------------------------------
localparam [3:0] S_RST = 4'h0;
localparam [3:0] S_VEC = 4'h1;
localparam [3:0] S_FETCH = 4'h2;
localparam [3:0] S_DEC = 4'h3;
localparam [3:0] S_SEXT = 4'h4;
localparam [3:0] S_SRD = 4'h5;
localparam [3:0] S_EXE = 4'h6;
localparam [3:0] S_DEXT = 4'h7;
localparam [3:0] S_DRD = 4'h8;
localparam [3:0] S_POP = 4'h9;
localparam [3:0] S_POPPC = 4'hA;

// ----------------------------------------
// functions
// ----------------------------------------
// pick the addressed byte lane, or the whole word
function [15:0] rcm_lane;
    input [15:0] w;
    input a0;
    input bw;
    begin
        rcm_lane = bw ? {8'h00, (a0 ? w[15:8] : w[7:0])} : w;
    end
endfunction

// result and flags: {update, v, n, z, c, result}
function [20:0] rcm_exec;
    input [15:0] ir;
    input [15:0] s;
    input [15:0] d;
    input cin;
    reg bw;
    reg sub;
    reg ci;
    reg cz;
    reg upd;
    reg c;
    reg v;
    reg carry;
    reg msb;
    reg zero;
    reg [15:0] a;
    reg [15:0] b;
    reg [15:0] op2;
    reg [15:0] r;
    reg [16:0] sum;
    reg [4:0] t;
    integer i;
    begin
        bw = ir[6];
        a = bw ? {8'h00, s[7:0]} : s;
        b = bw ? {8'h00, d[7:0]} : d;
        sub = (ir[15:12] == `RCM_OP_SUBC) || (ir[15:12] == `RCM_OP_SUB) || (ir[15:12] == `RCM_OP_CMP);
        op2 = sub ? (bw ? {8'h00, ~a[7:0]} : ~a) : a;
        ci = (ir[15:12] == `RCM_OP_ADDC || ir[15:12] == `RCM_OP_SUBC) ? cin : (ir[15:12] == `RCM_OP_SUB ||
            ir[15:12] == `RCM_OP_CMP);
        sum = {1'b0, b} + {1'b0, op2} + {16'h0000, ci};
        r = 16'h0000;
        c = cin;
        v = 1'b0;
        upd = 1'b1;
        cz = 1'b0;
        carry = cin;
        t = 5'h00;
        if (ir[15:10] == 6'b000100) begin
            case (ir[9:7])
                `RCM_F2_ROTC: begin
                    r = bw ? {8'h00, cin, a[7:1]} : {cin, a[15:1]};
                    c = a[0];
                end
                `RCM_F2_SWAP: begin
                    r = {s[7:0], s[15:8]};
                    upd = 1'b0;
                end
                `RCM_F2_ROTA: begin
                    r = bw ? {8'h00, a[7], a[7:1]} : {a[15], a[15:1]};
                    c = a[0];
                end
                `RCM_F2_SEXT: begin
                    r = {{8{s[7]}}, s[7:0]};
                    cz = 1'b1;
                end
                default: begin
                    r = a;
                    upd = 1'b0;
                end
            endcase
        end else begin
            case (ir[15:12])
                `RCM_OP_MOVE: begin
                    r = a;
                    upd = 1'b0;
                end
                `RCM_OP_ADD, `RCM_OP_ADDC, `RCM_OP_SUBC, `RCM_OP_SUB, `RCM_OP_CMP: begin
                    r = sum[15:0];
                    c = bw ? sum[8] : sum[16];
                    v = bw ? ((op2[7] == b[7]) && (r[7] != b[7])) : ((op2[15] == b[15]) && (r[15] != b[15]));
                end
                `RCM_OP_DECADD: begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if ((i < 2) || !bw) begin
                            t = {1'b0, b[i*4 +: 4]} + {1'b0, a[i*4 +: 4]} + {4'h0, carry};
                            if (t > 5'h09) begin
                                t = t + 5'h06;
                            end
                            carry = t[4];
                            r[i*4 +: 4] = t[3:0];
                        end
                    end
                    c = carry;
                end
                `RCM_OP_BITTEST, `RCM_OP_AND: begin
                    r = a & b;
                    cz = 1'b1;
                end
                `RCM_OP_BITCLR: begin
                    r = ~a & b;
                    upd = 1'b0;
                end
                `RCM_OP_BITSET: begin
                    r = a | b;
                    upd = 1'b0;
                end
                default: begin
                    r = a ^ b;
                    cz = 1'b1;
                    v = bw ? (a[7] & b[7]) : (a[15] & b[15]);
                end
            endcase
        end
        if (bw && !(ir[15:10] == 6'b000100 && (ir[9:7] == `RCM_F2_SWAP || ir[9:7] == `RCM_F2_SEXT))) begin
            r = {8'h00, r[7:0]};
        end
        msb = bw ? r[7] : r[15];
        zero = bw ? (r[7:0] == 8'h00) : (r == 16'h0000);
        if (cz) begin
            c = ~zero;
        end
        rcm_exec = {upd, v, msb, zero, c, r};
    end
endfunction

// ----------------------------------------
// state and decode
// ----------------------------------------
reg [15:0] rf [0:15];
reg [3:0] state_reg;
reg [15:0] ir_reg;
reg [15:0] src_val_reg;
reg [19:0] src_addr_reg;
reg [19:0] dst_addr_reg;
reg [3:0] ext_src_reg;
reg [3:0] ext_dst_reg;
integer k;

wire [15:0] cur_ir = (state_reg == S_DEC) ? mem_rdata_in : ir_reg;
wire fmt1 = cur_ir[15:14] != 2'b00;
wire fmt2 = cur_ir[15:10] == 6'b000100;
wire jmp = cur_ir[15:13] == 3'b001;
wire pfx = cur_ir[15:11] == 5'b00011;
wire [3:0] sn = fmt1 ? cur_ir[11:8] : cur_ir[3:0];
wire [3:0] dn = cur_ir[3:0];
wire [1:0] as = cur_ir[5:4];
wire ad = cur_ir[7];
wire bw = cur_ir[6];
wire [2:0] op2 = cur_ir[9:7];
wire [15:0] sr = rf[`RCM_REG_SR];
wire [15:0] pc = rf[`RCM_REG_PC];
wire [15:0] sp = rf[`RCM_REG_SP];
wire [15:0] spm2 = sp - 16'h0002;
// constant generator and absolute mode keep these two registers out of plain indirection
wire cg = (sn == `RCM_REG_CG) || ((sn == `RCM_REG_SR) && as[1]);
wire [15:0] cg_val = (sn == `RCM_REG_SR) ? (as[0] ? 16'h0008 : 16'h0004) :
    ((as == 2'b00) ? 16'h0000 : ((as == 2'b01) ? 16'h0001 : ((as == 2'b10) ? 16'h0002 : 16'hFFFF)));
wire [15:0] src_now = cg ? cg_val : rf[sn];
wire src_direct = (as == 2'b00) || cg;
wire [15:0] inc = (bw && sn != `RCM_REG_PC && sn != `RCM_REG_SP) ? 16'h0001 : 16'h0002;
wire [15:0] sv = (state_reg == S_DEC) ? src_now : src_val_reg;
wire [15:0] dv = (state_reg == S_DRD) ? rcm_lane(mem_rdata_in, dst_addr_reg[0], bw) : rf[dn];
wire [20:0] ex = rcm_exec(cur_ir, sv, dv, sr[`RCM_SR_C]);
wire [15:0] res = ex[15:0];
wire writes = fmt2 || (cur_ir[15:12] != `RCM_OP_CMP && cur_ir[15:12] != `RCM_OP_BITTEST);
wire f2_alu = fmt2 && !op2[2];
wire fast = (fmt1 && !ad && src_direct) || (f2_alu && as == 2'b00);
wire reg_wb = ((state_reg == S_DEC) && fast) ||
    ((state_reg == S_EXE) && ((fmt1 && !ad) || (f2_alu && as == 2'b00)));
wire mem_flag = (state_reg == S_DRD) || ((state_reg == S_EXE) && f2_alu && as != 2'b00);
wire [15:0] idx_base = (sn == `RCM_REG_SR) ? 16'h0000 : ((sn == `RCM_REG_PC) ? pc - 16'h0002 : rf[sn]);
wire [15:0] dst_base = (dn == `RCM_REG_SR) ? 16'h0000 : ((dn == `RCM_REG_PC) ? pc - 16'h0002 : rf[dn]);
wire [15:0] jmp_tgt = pc + {{5{cur_ir[9]}}, cur_ir[9:0], 1'b0};
reg taken;

always @* begin
    case (cur_ir[12:10])
        3'h0: taken = !sr[`RCM_SR_Z];
        3'h1: taken = sr[`RCM_SR_Z];
        3'h2: taken = !sr[`RCM_SR_C];
        3'h3: taken = sr[`RCM_SR_C];
        3'h4: taken = sr[`RCM_SR_N];
        3'h5: taken = !(sr[`RCM_SR_N] ^ sr[`RCM_SR_V]);
        3'h6: taken = sr[`RCM_SR_N] ^ sr[`RCM_SR_V];
        default: taken = 1'b1;
    endcase
end

// ----------------------------------------
// sequencer; one bus for memory and peripherals alike
// ----------------------------------------
always @(posedge sys_clk_in) begin
    if (rst_in) begin
        for (k = 0; k < 16; k = k + 1) begin
            rf[k] <= `RCM_REG_RESET;
        end
        state_reg <= S_RST;
        ir_reg <= 16'h0000;
        src_val_reg <= 16'h0000;
        src_addr_reg <= 20'h00000;
        dst_addr_reg <= 20'h00000;
        ext_src_reg <= 4'h0;
        ext_dst_reg <= 4'h0;
        mem_addr_out <= 20'h00000;
        mem_wdata_out <= 16'h0000;
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        mem_byte_out <= 1'b0;
    end else begin
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        mem_byte_out <= 1'b0;
        case (state_reg)
            S_RST: begin
                mem_addr_out <= `RCM_RESET_VECTOR;
                mem_rd_out <= 1'b1;
                state_reg <= S_VEC;
            end
            S_VEC: begin
                rf[`RCM_REG_PC] <= mem_rdata_in;
                state_reg <= S_FETCH;
            end
            S_FETCH: begin
                mem_addr_out <= {4'h0, pc};
                mem_rd_out <= 1'b1;
                rf[`RCM_REG_PC] <= pc + 16'h0002;
                ext_src_reg <= 4'h0;
                ext_dst_reg <= 4'h0;
                state_reg <= S_DEC;
            end
            S_DEC: begin
                ir_reg <= mem_rdata_in;
                if (pfx || (jmp && !taken) || (fast && !(writes && dn == `RCM_REG_PC))) begin
                    // issuing the next fetch here keeps register operations at one per cycle
                    mem_addr_out <= {4'h0, pc};
                    mem_rd_out <= 1'b1;
                    rf[`RCM_REG_PC] <= pc + 16'h0002;
                    ext_src_reg <= pfx ? mem_rdata_in[10:7] : 4'h0;
                    ext_dst_reg <= pfx ? mem_rdata_in[3:0] : 4'h0;
                end else if (jmp) begin
                    rf[`RCM_REG_PC] <= jmp_tgt;
                    state_reg <= S_FETCH;
                end else if (fast) begin
                    state_reg <= S_FETCH;
                end else if (as == 2'b01 && !cg) begin
                    mem_addr_out <= {4'h0, pc};
                    mem_rd_out <= 1'b1;
                    rf[`RCM_REG_PC] <= pc + 16'h0002;
                    state_reg <= S_SEXT;
                end else if (as[1] && !cg) begin
                    mem_addr_out <= {ext_src_reg, rf[sn]};
                    mem_rd_out <= 1'b1;
                    src_addr_reg <= {ext_src_reg, rf[sn]};
                    if (as[0]) begin
                        rf[sn] <= rf[sn] + inc;
                    end
                    state_reg <= S_SRD;
                end else begin
                    src_val_reg <= src_now;
                    src_addr_reg <= 20'h00000;
                    state_reg <= S_EXE;
                end
            end
            S_SEXT: begin
                mem_addr_out <= {ext_src_reg, idx_base + mem_rdata_in};
                mem_rd_out <= 1'b1;
                src_addr_reg <= {ext_src_reg, idx_base + mem_rdata_in};
                state_reg <= S_SRD;
            end
            S_SRD: begin
                src_val_reg <= rcm_lane(mem_rdata_in, src_addr_reg[0], bw);
                state_reg <= S_EXE;
            end
            S_EXE: begin
                state_reg <= S_FETCH;
                if (fmt1 && ad) begin
                    mem_addr_out <= {4'h0, pc};
                    mem_rd_out <= 1'b1;
                    rf[`RCM_REG_PC] <= pc + 16'h0002;
                    state_reg <= S_DEXT;
                end else if (f2_alu && as != 2'b00) begin
                    mem_addr_out <= src_addr_reg;
                    mem_wdata_out <= bw ? {res[7:0], res[7:0]} : res;
                    mem_byte_out <= bw;
                    mem_wr_out <= 1'b1;
                end else if (fmt2 && (op2 == `RCM_F2_PUSH || op2 == `RCM_F2_CALL)) begin
                    rf[`RCM_REG_SP] <= spm2;
                    mem_addr_out <= {4'h0, spm2};
                    mem_wr_out <= 1'b1;
                    if (op2 == `RCM_F2_CALL) begin
                        mem_wdata_out <= pc;
                        rf[`RCM_REG_PC] <= sv;
                    end else begin
                        mem_wdata_out <= bw ? {sv[7:0], sv[7:0]} : sv;
                        mem_byte_out <= bw;
                    end
                end else if (fmt2 && op2 == `RCM_F2_RETI) begin
                    mem_addr_out <= {4'h0, sp};
                    mem_rd_out <= 1'b1;
                    rf[`RCM_REG_SP] <= sp + 16'h0002;
                    state_reg <= S_POP;
                end
            end
            S_DEXT: begin
                mem_addr_out <= {ext_dst_reg, dst_base + mem_rdata_in};
                mem_rd_out <= 1'b1;
                dst_addr_reg <= {ext_dst_reg, dst_base + mem_rdata_in};
                state_reg <= S_DRD;
            end
            S_DRD: begin
                if (writes) begin
                    mem_addr_out <= dst_addr_reg;
                    mem_wdata_out <= bw ? {res[7:0], res[7:0]} : res;
                    mem_byte_out <= bw;
                    mem_wr_out <= 1'b1;
                end
                state_reg <= S_FETCH;
            end
            S_POP: begin
                rf[`RCM_REG_SR] <= mem_rdata_in;
                mem_addr_out <= {4'h0, sp};
                mem_rd_out <= 1'b1;
                rf[`RCM_REG_SP] <= sp + 16'h0002;
                state_reg <= S_POPPC;
            end
            S_POPPC: begin
                rf[`RCM_REG_PC] <= mem_rdata_in;
                state_reg <= S_FETCH;
            end
            default: begin
                state_reg <= S_RST;
            end
        endcase
        if ((reg_wb || mem_flag) && ex[20]) begin
            rf[`RCM_REG_SR] <= {sr[15:9], ex[19], sr[7:3], ex[18], ex[17], ex[16]};
        end
        // a result aimed at the status register overrides the flags it would produce
        if (reg_wb && writes && dn != `RCM_REG_CG) begin
            rf[dn] <= res;
        end
    end
end

endmodule

`default_nettype wire

// ---- test/rcm_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcm_mem_model (
    input wire logic sys_clk_in,
    input wire logic [19:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic byte_in,
    output logic [15:0] rdata_out
);
    // ----------------------------------------
    // zero-wait memory and peripheral space
    // ----------------------------------------
    logic [15:0] mem [0:32767];
    logic [15:0] word;
    assign word = mem[addr_in[15:1]];
    // inverted word while unselected, so stale data never passes for an answer
    assign rdata_out = rd_in ? word : ~word;
    always @(posedge sys_clk_in) begin
        if (wr_in && !byte_in) begin
            mem[addr_in[15:1]] <= wdata_in;
        end else if (wr_in && addr_in[0]) begin
            mem[addr_in[15:1]][15:8] <= wdata_in[15:8];
        end else if (wr_in) begin
            mem[addr_in[15:1]][7:0] <= wdata_in[7:0];
        end
    end
endmodule
`default_nettype wire

// ---- test/rcm_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcm_core_sva (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [15:0] mem_rdata_in,
    input wire logic [19:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic mem_byte_out
);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_release;
        $fell(rst_in);
    endsequence
    sequence s_vector_read;
        mem_rd_out && mem_addr_out == 20'h0FFFE;
    endsequence
    // register-only encoding read; bench data words are chosen never to match it
    sequence s_rr_fetch;
        mem_rd_out && mem_rdata_in[15:14] != 2'b00 && mem_rdata_in[7] == 1'b0 && mem_rdata_in[5:4] == 2'b00
            && mem_rdata_in[11:10] != 2'b00 && mem_rdata_in[3:2] != 2'b00;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_reset_quiet: assert property (@(posedge sys_clk_in) rst_in |=>
        !mem_rd_out && !mem_wr_out && !mem_byte_out && mem_addr_out == 20'h0 && mem_wdata_out == 16'h0)
        else $error("outputs not cleared by reset");
    chk_vector_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_release |=> s_vector_read) else $error("no vector read after reset");
    chk_rr_one_cycle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_rr_fetch |=> mem_rd_out && mem_addr_out == $past(mem_addr_out) + 20'h2)
        else $error("register operation took more than one cycle");
    chk_wr_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_wr_out |=> !mem_wr_out) else $error("write strobe longer than one cycle");
    chk_wr_fetch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_wr_out |=> mem_rd_out) else $error("write not followed by a read");
    chk_rd_wr_apart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(mem_rd_out && mem_wr_out)) else $error("read and write strobes together");
    chk_byte_lanes: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_wr_out && mem_byte_out |-> mem_wdata_out[15:8] == mem_wdata_out[7:0])
        else $error("byte write not replicated");
    chk_word_even: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_wr_out && !mem_byte_out |-> !mem_addr_out[0]) else $error("word write at odd address");
    chk_wdata_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        mem_wr_out |=> $stable(mem_wdata_out)) else $error("write data not held");
endmodule
bind rcm_core rcm_core_sva chk_i (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out),
    .mem_byte_out(mem_byte_out)
);
`default_nettype wire

// ---- test/tb_risc_core_register_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_risc_core_register_model;
    typedef struct {logic [15:0] op; logic [15:0] exp;} rcm_row_t;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] mem_rdata;
    logic [19:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic mem_byte;
    int error_cnt = 0;
    int n_tests = 0;
    logic [15:0] prog [$];
    rcm_row_t rows [25];

    always #12.5 sys_clk_in = ~sys_clk_in;

    rcm_core uut (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .mem_rdata_in(mem_rdata),
        .mem_addr_out(mem_addr),
        .mem_wdata_out(mem_wdata),
        .mem_rd_out(mem_rd),
        .mem_wr_out(mem_wr),
        .mem_byte_out(mem_byte)
    );
    rcm_mem_model mem_i (
        .sys_clk_in(sys_clk_in),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rd_in(mem_rd),
        .wr_in(mem_wr),
        .byte_in(mem_byte),
        .rdata_out(mem_rdata)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // loads prog at 0x4000 with a store of register five and a halt loop, then resets
    task automatic boot();
        int i;
        @(negedge sys_clk_in);
        rst_in = 1'b1;
        prog.push_back(16'h4582);
        prog.push_back(16'h0200);
        prog.push_back(16'h3FFF);
        for (i = 0; i < prog.size(); i++) begin
            mem_i.mem[15'h2000 + i] = prog[i];
        end
        repeat (12) @(negedge sys_clk_in);
        check(mem_addr, 20'h0);
        check({1'b0, mem_wdata, mem_rd, mem_wr, mem_byte}, 20'h0);
        rst_in = 1'b0;
        @(negedge sys_clk_in);
        check(mem_addr, 20'h0FFFE);
        check({19'h0, mem_rd}, 20'h1);
    endtask

    task automatic wait_wr(input logic [19:0] a, input logic [15:0] d, input logic b);
        int k;
        k = 0;
        while (mem_wr !== 1'b1 && k < 200) begin
            @(negedge sys_clk_in);
            k++;
        end
        if (mem_wr !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t no write seen", $time);
            conclude();
        end else begin
            check(mem_addr, a);
            check({4'h0, mem_wdata}, {4'h0, d});
            check({19'h0, mem_byte}, {19'h0, b});
            @(negedge sys_clk_in);
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem_i.mem[i] = 16'h0000;
        end
        mem_i.mem[15'h7FFF] = 16'h4000;
        mem_i.mem[15'h0180] = 16'h5A5A;
        rows = '{'{16'h4405, 16'h0135}, '{16'h5405, 16'h037B}, '{16'h6405, 16'h037B}, '{16'h7405, 16'h0110},
            '{16'h8405, 16'h0111}, '{16'h9405, 16'h0246}, '{16'hA405, 16'h0381}, '{16'hB405, 16'h0246},
            '{16'hC405, 16'h0242}, '{16'hD405, 16'h0377}, '{16'hE405, 16'h0373}, '{16'hF405, 16'h0004},
            '{16'h4445, 16'h0035}, '{16'h5445, 16'h007B}, '{16'hE445, 16'h0073}, '{16'h4305, 16'h0000},
            '{16'h4315, 16'h0001}, '{16'h4325, 16'h0002}, '{16'h4335, 16'hFFFF}, '{16'h4225, 16'h0004},
            '{16'h4235, 16'h0008}, '{16'h1005, 16'h0123}, '{16'h1085, 16'h4602}, '{16'h1105, 16'h0123},
            '{16'h1185, 16'h0046}};
        foreach (rows[r]) begin
            prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, rows[r].op};
            boot();
            wait_wr(20'h00200, rows[r].exp, 1'b0);
        end
        // back-to-back register operations
        prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, 16'h5405, 16'h5505, 16'hE405};
        boot();
        wait_wr(20'h00200, 16'h07C3, 1'b0);
        // a write to the constant source leaves its constant intact
        prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, 16'h4403, 16'h4305};
        boot();
        wait_wr(20'h00200, 16'h0000, 1'b0);
        // push through the stack pointer
        prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, 16'h4031, 16'h0400, 16'h1204, 16'h1244};
        boot();
        wait_wr(20'h003FE, 16'h0135, 1'b0);
        wait_wr(20'h003FC, 16'h3535, 1'b1);
        wait_wr(20'h00200, 16'h0246, 1'b0);
        // byte store to the high lane
        prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, 16'h44C2, 16'h0201};
        boot();
        wait_wr(20'h00201, 16'h3535, 1'b1);
        wait_wr(20'h00200, 16'h0246, 1'b0);
        // absolute read of a peripheral location
        prog = '{16'h4215, 16'h0300};
        boot();
        wait_wr(20'h00200, 16'h5A5A, 1'b0);
        // compare, a jump not taken, then a taken one that skips a clear
        prog = '{16'h4034, 16'h0135, 16'h4035, 16'h0246, 16'h9405, 16'h2401, 16'h4405, 16'h2001, 16'h4305};
        boot();
        wait_wr(20'h00200, 16'h0135, 1'b0);
        // address prefix lifts the destination into the upper range
        prog = '{16'h4035, 16'h0246, 16'h1801};
        boot();
        wait_wr(20'h10200, 16'h0246, 1'b0);
        // subroutine call pushes the return address and skips one word
        prog = '{16'h4031, 16'h0400, 16'h4034, 16'h400C, 16'h1284, 16'h4335};
        boot();
        wait_wr(20'h003FE, 16'h400A, 1'b0);
        wait_wr(20'h00200, 16'h0000, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
